/* include/rtsf_pkg.sv */
package rtsf_pkg;

    // ==========================================================
    // Clock rates
    // ==========================================================
    localparam int unsigned MCLK_HZ = 125_000_000;
    localparam int unsigned MCLK_PER_US = MCLK_HZ / 1_000_000;
    localparam int unsigned OSC_HZ = 32768;

    // ==========================================================
    // Crystal divider layout
    // ==========================================================
    // Tick bit k pulses at OSC_HZ / 2**(k+1)
    localparam int unsigned DIV_W = 15;
    localparam int unsigned TICK_8192 = 1;
    localparam int unsigned TICK_4096 = 2;
    localparam int unsigned TICK_128 = 7;
    localparam int unsigned TICK_64 = 8;
    localparam int unsigned TICK_1HZ = 14;
    localparam logic [5:0] SEC_LAST = 6'h3B;

    // ==========================================================
    // Timing
    // ==========================================================
    // Oscillator silence taken as a stop (longest wait, rounds down)
    localparam int unsigned OSC_TIMEOUT_US = 100;
    localparam int unsigned OSC_TIMEOUT_CYC = OSC_TIMEOUT_US * MCLK_PER_US;
    // Battery load settling before the compare (least time, rounds up)
    localparam int unsigned BAT_SETTLE_US = 10;
    localparam int unsigned BAT_SETTLE_CYC =
        (BAT_SETTLE_US * MCLK_HZ + 999_999) / 1_000_000;

    // ==========================================================
    // Encodings
    // ==========================================================
    localparam logic [1:0] CSEL_4096 = 2'h0;
    localparam logic [1:0] CSEL_64 = 2'h1;
    localparam logic [1:0] CSEL_1HZ = 2'h2;
    localparam logic [1:0] CSEL_MINUTE = 2'h3;
    localparam logic [3:0] SQW_OFF = 4'h0;
    localparam logic [3:0] SQW_FULL = 4'h1;
    localparam logic [1:0] LEAP_CENTURY = 2'h0;
    localparam logic [7:0] COUNT_LAST = 8'h01;
    localparam logic [7:0] COUNT_OFF = 8'h00;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] COUNTDOWN_RESET = 8'h00;
    localparam logic OSC_FAIL_RESET = 1'b1;
    localparam logic BAT_LOW_RESET = 1'b0;
    localparam logic [1:0] CENTURY_RESET = 2'h0;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic countdown_on;
        logic pulse_select;
        logic irq_enable;
        logic [1:0] clock_select;
    } rtsf_timer_ctrl_t;

    localparam rtsf_timer_ctrl_t TIMER_CTRL_RESET = '{
        countdown_on: 1'b0,
        pulse_select: 1'b0,
        irq_enable: 1'b0,
        clock_select: CSEL_MINUTE
    };

    typedef struct packed {
        logic osc_level;
        logic [DIV_W-1:0] div;
        logic [DIV_W-1:0] tick;
        logic minute_tick;
        logic osc_stopped;
    } rtsf_osc_t;

endpackage : rtsf_pkg

/* core/rtsf_osc_div.sv */
`timescale 1ns/1ps
`default_nettype none

module rtsf_osc_div
#(
    parameter int unsigned OSC_TIMEOUT_CYC = rtsf_pkg::OSC_TIMEOUT_CYC
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic osc_clk,
    input wire logic osc_halt,
    output rtsf_pkg::rtsf_osc_t osc
);
    import rtsf_pkg::*;

    localparam int unsigned TO_W = $clog2(OSC_TIMEOUT_CYC + 1);
    localparam logic [TO_W-1:0] TO_LIMIT = TO_W'(OSC_TIMEOUT_CYC);

    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic osc_edge;
    logic [DIV_W-1:0] div;
    logic [5:0] sec;
    logic [TO_W-1:0] silent;

    // ==========================================================
    // Crystal clock sampling
    // ==========================================================
    // Two flops before anything looks at the crystal level
    always_ff @(posedge mclk)
    begin
        osc_meta <= osc_clk;
        osc_sync <= osc_meta;
        osc_prev <= osc_sync;
    end

    // A halted oscillator yields no edges even if the pin toggles
    assign osc_edge = osc_sync & ~osc_prev & ~osc_halt;

    // ==========================================================
    // Binary divider and minute stage
    // ==========================================================
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            div <= '0;
        end
        else if (osc_edge)
        begin
            div <= div + 1'b1;
        end
    end

    // One tick per divider bit, each one mclk cycle wide
    for (genvar k = 0; k < DIV_W; k++)
    begin : g_tick
        always_ff @(posedge mclk)
        begin
            if (!reset_n)
            begin
                osc.tick[k] <= 1'b0;
            end
            else
            begin
                osc.tick[k] <= osc_edge & (&div[k:0]);
            end
        end
    end

    // Divide the 1 Hz tick by sixty for the slowest timer source
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            sec <= '0;
            osc.minute_tick <= 1'b0;
        end
        else
        begin
            osc.minute_tick <= osc.tick[TICK_1HZ] && sec == SEC_LAST;
            if (osc.tick[TICK_1HZ])
            begin
                sec <= (sec == SEC_LAST) ? 6'h00 : sec + 6'h01;
            end
        end
    end

    // ==========================================================
    // Stop detection
    // ==========================================================
    // Silence longer than the timeout, or a halt request, is a stop
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            silent <= '0;
            osc.osc_stopped <= 1'b1;
        end
        else
        begin
            if (osc_edge)
            begin
                silent <= '0;
            end
            else if (silent != TO_LIMIT)
            begin
                silent <= silent + 1'b1;
            end
            osc.osc_stopped <= osc_halt || silent == TO_LIMIT;
        end
    end

    // Registered copies for square-wave use
    always_ff @(posedge mclk)
    begin
        osc.osc_level <= osc_sync;
        osc.div <= div;
    end

endmodule : rtsf_osc_div

`default_nettype wire

/* core/rtsf_top.sv */
`timescale 1ns/1ps
`default_nettype none

module rtsf_top
#(
    parameter int unsigned OSC_TIMEOUT_CYC = rtsf_pkg::OSC_TIMEOUT_CYC,
    parameter int unsigned BAT_SETTLE_CYC = rtsf_pkg::BAT_SETTLE_CYC
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic osc_clk,
    input wire logic main_supply_ok,
    input wire logic battery_below_threshold,
    input wire logic flags_read,
    input wire logic osc_fail_clear,
    input wire logic countdown_value_wr,
    input wire logic [7:0] countdown_value_wdata,
    input wire logic timer_ctrl_wr,
    input wire rtsf_pkg::rtsf_timer_ctrl_t timer_ctrl_wdata,
    input wire logic [3:0] square_rate_select,
    input wire logic square_out_enable,
    input wire logic osc_halt,
    input wire logic osc_fail_irq_enable,
    input wire logic backup_irq_enable,
    input wire logic midnight_rollover,
    input wire logic century_rollover,
    input wire logic [6:0] year_in_century,
    input wire logic shared_irq_in,
    output rtsf_pkg::rtsf_timer_ctrl_t timer_ctrl,
    output logic [7:0] countdown_value,
    output logic timer_flag,
    output logic square_wave_pin,
    output logic battery_low_flag,
    output logic battery_load_on,
    output logic [1:0] century_count,
    output logic leap_year,
    output logic osc_fail_flag,
    output logic shared_irq_out,
    output logic shared_irq_oe_n
);
    import rtsf_pkg::*;

    localparam int unsigned SET_W = $clog2(BAT_SETTLE_CYC + 1);
    localparam logic [SET_W-1:0] SET_LIMIT = SET_W'(BAT_SETTLE_CYC);

    typedef enum logic [1:0] {
        BAT_IDLE,
        BAT_LOAD,
        BAT_COMPARE
    } rtsf_bat_state_t;

    rtsf_osc_t osc;
    logic vcc_meta;
    logic vcc_ok;
    logic vcc_prev;
    logic vcc_rise;
    logic vcc_fall;
    logic bat_meta;
    logic bat_low_sync;
    logic [7:0] reload_value;
    logic timer_run;
    logic src_tick;
    logic half_tick;
    logic release_tick;
    logic reload_event;
    logic pulse_low;
    logic timer_irq;
    logic osc_irq;
    logic irq_assert;
    logic [3:0] sqw_index;
    logic sqw_level;
    rtsf_bat_state_t bat_state;
    logic [SET_W-1:0] settle;
    logic shared_irq_unused;

    // Pin readback is not needed by this logic
    assign shared_irq_unused = shared_irq_in;

    // ==========================================================
    // Crystal divider
    // ==========================================================
    rtsf_osc_div #(
        .OSC_TIMEOUT_CYC(OSC_TIMEOUT_CYC)
    ) u_osc_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .osc_clk(osc_clk),
        .osc_halt(osc_halt),
        .osc(osc)
    );

    // ==========================================================
    // Supply and battery comparator sampling
    // ==========================================================
    // Both come from analog circuits, so two flops each
    always_ff @(posedge mclk)
    begin
        vcc_meta <= main_supply_ok;
        vcc_ok <= vcc_meta;
        bat_meta <= battery_below_threshold;
        bat_low_sync <= bat_meta;
    end

    // Supply edges; reset state counts as powered down
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            vcc_prev <= 1'b0;
        end
        else
        begin
            vcc_prev <= vcc_ok;
        end
    end

    assign vcc_rise = vcc_ok & ~vcc_prev;
    assign vcc_fall = ~vcc_ok & vcc_prev;

    // ==========================================================
    // Timer control
    // ==========================================================
    // Power-down wins over a write in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            timer_ctrl <= TIMER_CTRL_RESET;
        end
        else if (vcc_fall)
        begin
            timer_ctrl.countdown_on <= 1'b0;
        end
        else if (timer_ctrl_wr)
        begin
            timer_ctrl <= timer_ctrl_wdata;
        end
    end

    // ==========================================================
    // Source tick selection
    // ==========================================================
    // half_tick ends a pulse early for n = 1 and 64 Hz for slow sources
    always_comb
    begin
        src_tick = 1'b0;
        half_tick = 1'b0;
        case (timer_ctrl.clock_select)
            CSEL_4096:
            begin
                src_tick = osc.tick[TICK_4096];
                half_tick = osc.tick[TICK_8192];
            end
            CSEL_64:
            begin
                src_tick = osc.tick[TICK_64];
                half_tick = osc.tick[TICK_128];
            end
            CSEL_1HZ:
            begin
                src_tick = osc.tick[TICK_1HZ];
                half_tick = osc.tick[TICK_64];
            end
            CSEL_MINUTE:
            begin
                src_tick = osc.minute_tick;
                half_tick = osc.tick[TICK_64];
            end
            default:
            begin
                src_tick = 1'b0;
                half_tick = 1'b0;
            end
        endcase
    end

    // Timer stops in backup; a zero reload value disables it
    assign timer_run = timer_ctrl.countdown_on && vcc_ok
        && reload_value != COUNT_OFF;
    assign reload_event = timer_run && src_tick && !countdown_value_wr
        && countdown_value <= COUNT_LAST;

    // ==========================================================
    // Countdown
    // ==========================================================
    // A write loads both reload and live count; a stop keeps the count
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            reload_value <= COUNTDOWN_RESET;
            countdown_value <= COUNTDOWN_RESET;
        end
        else if (countdown_value_wr)
        begin
            reload_value <= countdown_value_wdata;
            countdown_value <= countdown_value_wdata;
        end
        else if (reload_event)
        begin
            countdown_value <= reload_value;
        end
        else if (timer_run && src_tick)
        begin
            countdown_value <= countdown_value - 8'h01;
        end
    end

    // Set wins over a read-clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            timer_flag <= 1'b0;
        end
        else if (reload_event)
        begin
            timer_flag <= 1'b1;
        end
        else if (flags_read)
        begin
            timer_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Free-running pulse output
    // ==========================================================
    // Slow sources keep the low time at 1/64 s; n = 1 uses half a period
    always_comb
    begin
        release_tick = src_tick;
        if (timer_ctrl.clock_select == CSEL_1HZ
            || timer_ctrl.clock_select == CSEL_MINUTE)
        begin
            release_tick = half_tick;
        end
        else if (reload_value == COUNT_LAST)
        begin
            release_tick = half_tick;
        end
    end

    // Reload drives low, next release edge lets it go high again
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            pulse_low <= 1'b0;
        end
        else if (!timer_ctrl.pulse_select || !timer_run)
        begin
            pulse_low <= 1'b0;
        end
        else if (reload_event)
        begin
            pulse_low <= 1'b1;
        end
        else if (release_tick)
        begin
            pulse_low <= 1'b0;
        end
    end

    // Flag clearing has no effect on the pulse form
    assign timer_irq = timer_ctrl.pulse_select ? pulse_low
        : (timer_flag & timer_ctrl.irq_enable);

    // ==========================================================
    // Square wave
    // ==========================================================
    // Code c >= 2 picks divider bit c-1, i.e. 2**(15-c) Hz
    assign sqw_index = square_rate_select - SQW_FULL;

    always_comb
    begin
        if (square_rate_select == SQW_OFF)
        begin
            sqw_level = 1'b0;
        end
        else if (square_rate_select == SQW_FULL)
        begin
            sqw_level = osc.osc_level;
        end
        else
        begin
            sqw_level = osc.div[sqw_index];
        end
    end

    // Forced low on backup so the pin draws nothing
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            square_wave_pin <= 1'b0;
        end
        else
        begin
            square_wave_pin <= square_out_enable & vcc_ok & sqw_level;
        end
    end

    // ==========================================================
    // Battery check
    // ==========================================================
    // Midnight check settles under load first; power-up compares at once
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            bat_state <= BAT_IDLE;
            settle <= '0;
            battery_load_on <= 1'b0;
            battery_low_flag <= BAT_LOW_RESET;
        end
        else if (!vcc_ok)
        begin
            bat_state <= BAT_IDLE;
            settle <= '0;
            battery_load_on <= 1'b0;
        end
        else
        begin
            case (bat_state)
                BAT_IDLE:
                begin
                    settle <= '0;
                    if (vcc_rise)
                    begin
                        bat_state <= BAT_COMPARE;
                    end
                    else if (midnight_rollover)
                    begin
                        bat_state <= BAT_LOAD;
                        battery_load_on <= 1'b1;
                    end
                end
                BAT_LOAD:
                begin
                    settle <= settle + 1'b1;
                    if (settle == SET_LIMIT)
                    begin
                        bat_state <= BAT_COMPARE;
                    end
                end
                BAT_COMPARE:
                begin
                    battery_low_flag <= bat_low_sync;
                    battery_load_on <= 1'b0;
                    bat_state <= BAT_IDLE;
                end
                default:
                begin
                    bat_state <= BAT_IDLE;
                    battery_load_on <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Century and leap year
    // ==========================================================
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            century_count <= CENTURY_RESET;
        end
        else if (century_rollover)
        begin
            century_count <= century_count + 2'h1;
        end
    end

    // Year 00 leaps only in the leap century (the 400-year case)
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            leap_year <= 1'b0;
        end
        else
        begin
            leap_year <= year_in_century[1:0] == 2'h0
                && (year_in_century != 7'h00
                || century_count == LEAP_CENTURY);
        end
    end

    // ==========================================================
    // Oscillator fail
    // ==========================================================
    // Starts set; a stop wins over a host clear; reads leave it alone
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            osc_fail_flag <= OSC_FAIL_RESET;
        end
        else if (osc.osc_stopped)
        begin
            osc_fail_flag <= 1'b1;
        end
        else if (osc_fail_clear)
        begin
            osc_fail_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Shared interrupt pin
    // ==========================================================
    assign osc_irq = osc_fail_flag & osc_fail_irq_enable;
    // Timer is dead on backup; only fail detection with backup enable
    assign irq_assert = vcc_ok ? (timer_irq | osc_irq)
        : (osc_irq & backup_irq_enable);

    // Open drain: enable low pulls the pin low
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            shared_irq_oe_n <= 1'b1;
        end
        else
        begin
            shared_irq_oe_n <= ~irq_assert;
        end
    end

    assign shared_irq_out = 1'b0;

endmodule : rtsf_top

`default_nettype wire

/* tb/rtsf_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Timer, fail-flag, battery, century checks
module rtsf_monitor
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic main_supply_ok,
    input wire logic osc_fail_clear,
    input wire logic osc_halt,
    input wire logic osc_fail_irq_enable,
    input wire logic backup_irq_enable,
    input wire logic midnight_rollover,
    input wire logic century_rollover,
    input wire rtsf_pkg::rtsf_timer_ctrl_t timer_ctrl,
    input wire logic [7:0] countdown_value,
    input wire logic timer_flag,
    input wire logic battery_load_on,
    input wire logic [1:0] century_count,
    input wire logic osc_fail_flag,
    input wire logic shared_irq_oe_n
);
    import rtsf_pkg::*;
    // Supply crosses two flops, so six cycles of settle are allowed
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_flag_on_reload: assert property ($rose(timer_flag) |->
        $past(countdown_value) == COUNT_LAST ||
        $past(countdown_value, 2) == COUNT_LAST) else $error("flag early");
    a_level_irq_on: assert property ((main_supply_ok &&
        timer_flag && timer_ctrl.irq_enable && !timer_ctrl.pulse_select)[*6]
        |=> !shared_irq_oe_n) else $error("timer irq missing");
    a_irq_enable_gate: assert property ((!timer_ctrl.pulse_select &&
        !timer_ctrl.irq_enable && !osc_fail_irq_enable)[*3]
        |-> shared_irq_oe_n) else $error("irq while disabled");
    a_halt_sets_fail: assert property (osc_halt |->
        ##[1:2] osc_fail_flag) else $error("halt missed");
    a_fail_write_only: assert property ($fell(osc_fail_flag) |->
        $past(osc_fail_clear)) else $error("fail flag lost");
    a_fail_irq_pin: assert property (((main_supply_ok ||
        backup_irq_enable) && osc_fail_irq_enable && osc_fail_flag)[*6]
        |=> !shared_irq_oe_n) else $error("fail irq missing");
    a_load_at_midnight: assert property ($rose(battery_load_on) |->
        $past(midnight_rollover)) else $error("stray load");
    a_century_binary: assert property ($changed(century_count) |->
        $past(century_rollover) &&
        century_count == 2'($past(century_count) + 2'h1))
        else $error("century step");
endmodule : rtsf_monitor

bind rtsf_top rtsf_monitor rtsf_monitor_inst (.mclk, .reset_n,
    .main_supply_ok, .osc_fail_clear, .osc_halt, .osc_fail_irq_enable,
    .backup_irq_enable, .midnight_rollover, .century_rollover,
    .timer_ctrl, .countdown_value, .timer_flag, .battery_load_on,
    .century_count, .osc_fail_flag, .shared_irq_oe_n);
`default_nettype wire

/* tb/rtsf_crystal_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Crystal feeding the oscillator input
module rtsf_crystal_model
(
    input wire logic run,
    output logic osc_clk
);
    // Odd start offset keeps it out of phase with mclk
    initial
    begin
        osc_clk = 1'h0;
        #37;
        forever #80 osc_clk = run ? ~osc_clk : osc_clk;
    end
endmodule : rtsf_crystal_model
`default_nettype wire

/* tb/rtsf_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

// ========================================
// Bench acting as host, supply and comparator
module rtc_timer_sqw_status_flags_bench;
    import rtsf_pkg::*;
    logic mclk = 1'h0, reset_n = 1'h0, osc_run = 1'h1, osc_clk;
    logic main_supply_ok = 1'h1, battery_below_threshold = 1'h0;
    logic flags_read = 1'h0, osc_fail_clear = 1'h0, osc_halt = 1'h0;
    logic countdown_value_wr = 1'h0, timer_ctrl_wr = 1'h0;
    logic square_out_enable = 1'h0, osc_fail_irq_enable = 1'h0;
    logic backup_irq_enable = 1'h0, midnight_rollover = 1'h0;
    logic century_rollover = 1'h0, shared_irq_out, shared_irq_oe_n;
    logic [7:0] countdown_value_wdata = 8'h00, countdown_value;
    logic [3:0] square_rate_select = 4'h0;
    logic [6:0] year_in_century = 7'h01;
    rtsf_timer_ctrl_t timer_ctrl_wdata = TIMER_CTRL_RESET, timer_ctrl;
    logic timer_flag, square_wave_pin, battery_low_flag, battery_load_on;
    logic leap_year, osc_fail_flag;
    logic [1:0] century_count;
    wire logic shared_irq_in;
    int err_count = 0, checks_done = 0;
    // Open-drain pin with its pull-up
    assign shared_irq_in = shared_irq_oe_n ? 1'h1 : shared_irq_out;
    initial forever #4 mclk = ~mclk;
    rtsf_crystal_model rtsf_crystal_model_inst (.run(osc_run), .osc_clk);
    rtsf_top #(.OSC_TIMEOUT_CYC(64), .BAT_SETTLE_CYC(16)) rtsf_top_inst (
        .mclk, .reset_n, .osc_clk, .main_supply_ok, .battery_below_threshold,
        .flags_read, .osc_fail_clear, .countdown_value_wr,
        .countdown_value_wdata, .timer_ctrl_wr, .timer_ctrl_wdata,
        .square_rate_select, .square_out_enable, .osc_halt,
        .osc_fail_irq_enable, .backup_irq_enable, .midnight_rollover,
        .century_rollover, .year_in_century, .shared_irq_in, .timer_ctrl,
        .countdown_value, .timer_flag, .square_wave_pin, .battery_low_flag,
        .battery_load_on, .century_count, .leap_year, .osc_fail_flag,
        .shared_irq_out, .shared_irq_oe_n);
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : step
    task automatic pulse(ref logic s);
        s = 1'h1;
        step(1);
        s = 1'h0;
    endtask : pulse
    task automatic ctl(input rtsf_timer_ctrl_t v);
        timer_ctrl_wdata = v;
        pulse(timer_ctrl_wr);
    endtask : ctl
    // Countdown of two at 4096 Hz, enable toggled, then a flags read
    task automatic timer_level();
        countdown_value_wdata = 8'h02;
        pulse(countdown_value_wr);
        ctl('{1'h1, 1'h0, 1'h1, CSEL_4096});
        for (int n = 0; n < 2000 && timer_flag !== 1'h1; n++)
            step(1);
        `CHK(countdown_value, 8'h02)
        step(2);
        `CHK(shared_irq_oe_n, 1'h0)
        ctl('{1'h1, 1'h0, 1'h0, CSEL_4096});
        step(2);
        `CHK({timer_flag, shared_irq_oe_n}, 2'h3)
        ctl('{1'h1, 1'h0, 1'h1, CSEL_4096});
        step(2);
        `CHK(shared_irq_oe_n, 1'h0)
        pulse(flags_read);
        step(2);
        `CHK({timer_flag, shared_irq_oe_n}, 2'h1)
        ctl('{1'h1, 1'h1, 1'h0, CSEL_4096});
        for (int n = 0; n < 400 && shared_irq_oe_n !== 1'h0; n++)
            step(1);
        `CHK(countdown_value, 8'h02)
        step(100);
        `CHK(shared_irq_oe_n, 1'h0)
        step(100);
        `CHK(shared_irq_oe_n, 1'h1)
        ctl(TIMER_CTRL_RESET);
    endtask : timer_level
    // Clear, stop the crystal, backup interrupt, restart, then a halt pulse
    task automatic osc_fail();
        pulse(osc_fail_clear);
        step(3);
        `CHK(osc_fail_flag, 1'h0)
        osc_fail_irq_enable = 1'h1;
        osc_run = 1'h0;
        step(200);
        pulse(flags_read);
        step(2);
        `CHK({osc_fail_flag, shared_irq_oe_n}, 2'h2)
        main_supply_ok = 1'h0;
        backup_irq_enable = 1'h1;
        step(10);
        `CHK(shared_irq_oe_n, 1'h0)
        backup_irq_enable = 1'h0;
        step(10);
        `CHK(shared_irq_oe_n, 1'h1)
        main_supply_ok = 1'h1;
        osc_run = 1'h1;
        pulse(osc_halt);
        step(200);
        pulse(osc_fail_clear);
        step(3);
        `CHK({osc_fail_flag, shared_irq_oe_n}, 2'h1)
        osc_fail_irq_enable = 1'h0;
    endtask : osc_fail
    // Loaded midnight check, a skipped one on backup, power-up check
    task automatic battery();
        battery_below_threshold = 1'h1;
        pulse(midnight_rollover);
        step(2);
        `CHK(battery_load_on, 1'h1)
        step(30);
        `CHK({battery_low_flag, battery_load_on}, 2'h2)
        main_supply_ok = 1'h0;
        battery_below_threshold = 1'h0;
        step(5);
        pulse(midnight_rollover);
        step(30);
        `CHK(battery_low_flag, 1'h1)
        main_supply_ok = 1'h1;
        step(10);
        `CHK(battery_low_flag, 1'h0)
    endtask : battery
    // Rising edges over 800 clocks, crystal 20 clocks a cycle
    task automatic square(input logic [3:0] code, input int rises);
        int seen = 0;
        logic last = 1'h0;
        square_rate_select = code;
        square_out_enable = 1'h1;
        step(20);
        repeat (800)
        begin
            step(1);
            seen += int'(square_wave_pin && !last);
            last = square_wave_pin;
        end
        `CHK(seen inside {[rises - 1:rises + 1]}, 1'h1)
        main_supply_ok = 1'h0;
        step(10);
        `CHK(square_wave_pin, 1'h0)
        main_supply_ok = 1'h1;
        square_out_enable = 1'h0;
        step(10);
        `CHK(square_wave_pin, 1'h0)
    endtask : square
    // Year zero through all four century codes
    task automatic century();
        year_in_century = 7'h00;
        for (int i = 0; i < 5; i++)
        begin
            step(4);
            `CHK(century_count, 2'(i))
            `CHK(leap_year, 1'(i % 4 == 0))
            pulse(century_rollover);
        end
    endtask : century
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    // Main sequence
    initial
    begin
        step(8);
        reset_n = 1'h1;
        step(4);
        timer_level();
        osc_fail();
        battery();
        square(4'h1, 40);
        square(4'h2, 10);
        square(4'h3, 5);
        square(4'h0, 0);
        century();
        results();
    end
    // About 5000 clocks needed; five times that
    initial
    begin
        #200000;
        err_count++;
        results();
    end
endmodule : rtc_timer_sqw_status_flags_bench
`default_nettype wire
